// *** core/zdb_pkg.sv ***
// constants, types and decode functions of the clock bank control
// assumes three-level pins arrive as 2-bit codes and reference pairs as one level each
package zdb_pkg;

   // ----------------------------------------
   // three-level pin codes
   // ----------------------------------------
   localparam logic [1:0] LVL_LOW = 2'h0;
   localparam logic [1:0] LVL_MID = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MASK = 4'h4;
   localparam logic [3:0] OFS_STATE = 4'h8;
   localparam logic [3:0] OFS_PERIOD = 4'hc;
   localparam int EV_GAIN = 0;
   localparam int EV_LOSS = 1;
   localparam int EV_SWAP = 2;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_TIMEOUT_NS = 20000;
   localparam logic [15:0] REF_TIMEOUT_CYC = 16'(REF_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam logic [1:0] ALIGN_WIN = 2'h3;
   localparam logic [2:0] LOCK_EDGES = 3'h4;
   localparam logic [5:0] N_LOW = 6'h20;
   localparam logic [5:0] N_MID = 6'h10;
   localparam logic [5:0] N_HIGH = 6'h08;

   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b00,
      ST_LOCKED = 2'b01,
      ST_TEST = 2'b10
   } lock_state_t;

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   // the unused code 3 reads as mid, like a floating pin
   function automatic logic [1:0] lvl(input logic [1:0] p);
      return (p == LVL_HIGH) ? LVL_HIGH : ((p == LVL_LOW) ? LVL_LOW : LVL_MID);
   endfunction : lvl

   function automatic logic [3:0] pair_idx(input logic [1:0] hi, input logic [1:0] lo);
      return 4'(3 * lvl(hi) + lvl(lo));
   endfunction : pair_idx

   function automatic logic [3:0] div_of(input logic [3:0] idx);
      case (idx)
         4'h0: return 4'h1;
         4'h1: return 4'h2;
         4'h2: return 4'h3;
         4'h3: return 4'h4;
         4'h4: return 4'h5;
         4'h5: return 4'h6;
         4'h6: return 4'h8;
         4'h7: return 4'ha;
         default: return 4'hc;
      endcase
   endfunction : div_of

   function automatic logic [5:0] n_of(input logic [1:0] p);
      return (lvl(p) == LVL_LOW) ? N_LOW : ((lvl(p) == LVL_MID) ? N_MID : N_HIGH);
   endfunction : n_of

endpackage : zdb_pkg

// *** core/zero_delay_clock_bank_control.sv ***
// control logic of a zero-delay clock fan-out buffer with two banks and a feedback output
// assumes pins synchronous to I_MCLK, pads resolved to logic levels, a classic Wishbone master
//
// Operation
// - select low picks primary reference, high alternate
// - undriven select reads low, primary chosen
// - feedback rising edges aligned to reference edges
// - phase selects offset each output group
// - divider selects set each bank's ratio
// - feedback phase select offsets feedback output
// - feedback divider selects set feedback ratio
// - bank off high disables, low enables bank
// - mode high gives high-z, low hold-off
// - mode mid enters factory test mode
// - lock output high only while locked
// - divider codes give 1,2,3,4,5,6,8,10,12
// - phase codes map to unit offsets
// - skew unit factor 32, 16 or 8
module zero_delay_clock_bank_control
   import zdb_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   input wire logic I_PRIMARY_REFERENCE_PAIR,
   input wire logic I_ALTERNATE_REFERENCE_PAIR,
   input wire logic I_REFERENCE_CHOOSER,
   input wire logic I_FEEDBACK_INPUT,
   input wire logic [1:0] I_RANGE_SELECT,
   input wire logic [1:0] I_MODE_SELECT,
   input wire logic [7:0] I_BANK_ONE_PHASE_SELECTS,
   input wire logic [3:0] I_BANK_TWO_PHASE_SELECTS,
   input wire logic [7:0] I_BANK_DIVIDER_SELECTS,
   input wire logic [1:0] I_FEEDBACK_PHASE_SELECT,
   input wire logic [3:0] I_FEEDBACK_DIVIDER_SELECTS,
   input wire logic [1:0] I_BANK_OFF_INPUTS,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [3:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   output logic [3:0] O_BANK_ONE_CLOCK_OUTS,
   output logic O_BANK_ONE_OE,
   output logic [5:0] O_BANK_TWO_CLOCK_OUTS,
   output logic O_BANK_TWO_OE,
   output logic O_FEEDBACK_CLOCK_OUT,
   output logic O_LOCK,
   output logic O_IRQ
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic signed [4:0] off_one(input logic [3:0] idx);
      return $signed({1'b0, idx}) - 5'sh04;
   endfunction : off_one

   function automatic logic signed [4:0] off_two(input logic [3:0] idx,
      input logic signed [4:0] lo, input logic signed [4:0] up);
      case (idx)
         4'h0: return 5'sh18;
         4'h1: return 5'sh19;
         4'h2: return 5'sh1a;
         4'h3: return lo;
         4'h4: return 5'sh00;
         4'h5: return up;
         4'h6: return 5'sh06;
         4'h7: return 5'sh07;
         default: return 5'sh08;
      endcase
   endfunction : off_two

   // folds v into 0..p-1; one fold suffices since offsets never exceed the shortest period
   function automatic logic [8:0] wrapc(input logic signed [10:0] v, input logic [8:0] p);
      if (v < 0) return 9'(v + $signed({2'h0, p}));
      else if (v >= $signed({2'h0, p})) return 9'(v - $signed({2'h0, p}));
      else return 9'(v);
   endfunction : wrapc

   function automatic logic high_phase(input logic [8:0] c, input logic signed [4:0] o,
      input logic [8:0] p);
      return wrapc($signed({2'h0, c}) - 11'(o), p) < (p >> 1);
   endfunction : high_phase

   function automatic logic [8:0] count_up(input logic [8:0] c, input logic [8:0] p);
      return ({1'b0, c} + 10'h001 >= {1'b0, p}) ? 9'h000 : c + 9'h001;
   endfunction : count_up

   typedef struct packed {
      lock_state_t st;
      logic rp;
      logic fp;
      logic sp;
      logic [15:0] pcnt;
      logic [15:0] per;
      logic [15:0] acc;
      logic [1:0] win;
      logic hit;
      logic [2:0] good;
      logic [8:0] c1;
      logic [8:0] c2;
      logic [8:0] cf;
      logic h1;
      logic h2;
      logic [3:0] q1;
      logic [5:0] q2;
      logic qf;
      logic oe1;
      logic oe2;
      logic lock;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
      logic ack;
      logic [31:0] dat;
   } core_t;

   core_t core;
   core_t next_core;

   // ----------------------------------------
   // decode of the pins
   // ----------------------------------------
   logic test;
   logic ref_now;
   logic ref_rise;
   logic fb_rise;
   logic tick;
   logic wr;
   logic off_low;
   logic off_high;
   logic [5:0] nf;
   logic [3:0] idx1;
   logic [3:0] idx2;
   logic [3:0] idxf;
   logic [8:0] per1;
   logic [8:0] per2;
   logic [8:0] perf;
   logic signed [4:0] o1l;
   logic signed [4:0] o1u;
   logic signed [4:0] o2;
   logic signed [4:0] of;
   logic [16:0] sum;
   logic r1l;
   logic r1u;
   logic r2;
   logic rf;
   logic [2:0] ev;
   logic [2:0] clr;

   assign test = (lvl(I_MODE_SELECT) == LVL_MID);
   assign off_low = (lvl(I_MODE_SELECT) == LVL_LOW);
   assign off_high = (lvl(I_MODE_SELECT) == LVL_HIGH);
   // only a driven one picks the alternate pair; the pad pull-down covers an open pin
   assign ref_now = (I_REFERENCE_CHOOSER == 1'b1) ? I_ALTERNATE_REFERENCE_PAIR : I_PRIMARY_REFERENCE_PAIR;
   assign ref_rise = ref_now & ~core.rp;
   assign fb_rise = I_FEEDBACK_INPUT & ~core.fp;
   assign nf = n_of(I_RANGE_SELECT);
   assign idx1 = pair_idx(I_BANK_DIVIDER_SELECTS[3:2], I_BANK_DIVIDER_SELECTS[1:0]);
   assign idx2 = pair_idx(I_BANK_DIVIDER_SELECTS[7:6], I_BANK_DIVIDER_SELECTS[5:4]);
   assign idxf = pair_idx(I_FEEDBACK_DIVIDER_SELECTS[3:2], I_FEEDBACK_DIVIDER_SELECTS[1:0]);
   assign per1 = 9'(div_of(idx1) * nf);
   assign per2 = 9'(div_of(idx2) * nf);
   assign perf = 9'(div_of(idxf) * nf);
   assign o1l = off_one(pair_idx(I_BANK_ONE_PHASE_SELECTS[3:2], I_BANK_ONE_PHASE_SELECTS[1:0]));
   assign o1u = off_one(pair_idx(I_BANK_ONE_PHASE_SELECTS[7:6], I_BANK_ONE_PHASE_SELECTS[5:4]));
   assign o2 = off_two(pair_idx(I_BANK_TWO_PHASE_SELECTS[3:2], I_BANK_TWO_PHASE_SELECTS[1:0]), o1l, o1u);
   assign of = (lvl(I_FEEDBACK_PHASE_SELECT) == LVL_LOW) ? 5'sh1c :
      ((lvl(I_FEEDBACK_PHASE_SELECT) == LVL_HIGH) ? 5'sh04 : 5'sh00);

   // ----------------------------------------
   // skew unit generator
   // ----------------------------------------
   // perf units fit in one reference period; at most one unit per cycle, so a reference
   // period shorter than perf cycles runs the outputs slow rather than faster than I_MCLK
   assign sum = {1'b0, core.acc} + {8'h00, perf};
   assign tick = (core.per != 16'h0000) && (sum >= {1'b0, core.per});
   assign r1l = high_phase(core.c1, o1l, per1);
   assign r1u = high_phase(core.c1, o1u, per1);
   assign r2 = high_phase(core.c2, o2, per2);
   assign rf = high_phase(core.cf, of, perf);
   assign wr = core.ack && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0];
   assign clr = (wr && I_WB_ADR == OFS_STATUS) ? I_WB_DAT[2:0] : 3'h0;

   always_comb begin
      next_core = core;
      ev = 3'h0;
      next_core.rp = ref_now;
      next_core.fp = I_FEEDBACK_INPUT;
      next_core.sp = I_REFERENCE_CHOOSER;

      // ----------------------------------------
      // reference period and unit counters
      // ----------------------------------------
      if (ref_rise) begin
         next_core.per = core.pcnt + 16'h0001;
         next_core.pcnt = 16'h0000;
      end else if (core.pcnt != REF_TIMEOUT_CYC) begin
         next_core.pcnt = core.pcnt + 16'h0001;
      end
      next_core.acc = tick ? 16'(sum - {1'b0, core.per}) : sum[15:0];
      if (tick) begin
         next_core.c1 = count_up(core.c1, per1);
         next_core.c2 = count_up(core.c2, per2);
         next_core.cf = count_up(core.cf, perf);
      end
      if (core.win != 2'h0) begin
         next_core.win = core.win - 2'h1;
         if (fb_rise) next_core.hit = 1'b1;
      end

      // ----------------------------------------
      // loop alignment and lock
      // ----------------------------------------
      unique case (core.st)
         ST_TEST: begin
            if (!test) next_core.st = ST_ACQUIRE;
         end
         ST_ACQUIRE, ST_LOCKED: begin
            if (test) begin
               next_core.st = ST_TEST;
               next_core.good = 3'h0;
            end else if (core.pcnt == REF_TIMEOUT_CYC) begin
               next_core.st = ST_ACQUIRE;
               next_core.good = 3'h0;
            end else if (ref_rise) begin
               next_core.win = ALIGN_WIN;
               next_core.hit = fb_rise;
               if (core.hit) begin
                  if (core.good != LOCK_EDGES) next_core.good = core.good + 3'h1;
                  if (core.good == LOCK_EDGES - 3'h1) next_core.st = ST_LOCKED;
               end else begin
                  // feedback missed the window: restart all dividers so that the
                  // feedback output rises now, in step with this reference edge
                  next_core.good = 3'h0;
                  next_core.st = ST_ACQUIRE;
                  next_core.c1 = wrapc(11'(of), per1);
                  next_core.c2 = wrapc(11'(of), per2);
                  next_core.cf = wrapc(11'(of), perf);
                  next_core.acc = 16'h0000;
               end
            end
         end
         default: next_core.st = ST_ACQUIRE;
      endcase
      next_core.lock = (next_core.st == ST_LOCKED);

      // ----------------------------------------
      // outputs, disable and hold-off
      // ----------------------------------------
      // hold-off flips only while the raw bank clock is low, so no runt pulse appears
      if (!(r1l | r1u)) next_core.h1 = I_BANK_OFF_INPUTS[0] && off_low;
      if (!r2) next_core.h2 = I_BANK_OFF_INPUTS[1] && off_low;
      next_core.oe1 = test || !(I_BANK_OFF_INPUTS[0] && off_high);
      next_core.oe2 = test || !(I_BANK_OFF_INPUTS[1] && off_high);
      if (test) begin
         next_core.q1 = {4{ref_now}};
         next_core.q2 = {6{ref_now}};
         next_core.qf = ref_now;
      end else begin
         next_core.q1 = {{2{r1u}}, {2{r1l}}} & {4{~next_core.h1}};
         next_core.q2 = {6{r2 & ~next_core.h2}};
         next_core.qf = rf;
      end

      // ----------------------------------------
      // events and bus slave
      // ----------------------------------------
      ev[EV_GAIN] = (next_core.st == ST_LOCKED) && (core.st != ST_LOCKED);
      ev[EV_LOSS] = (core.st == ST_LOCKED) && (next_core.st != ST_LOCKED);
      ev[EV_SWAP] = (I_REFERENCE_CHOOSER != core.sp);
      // a new event beats a write-one-to-clear in the same cycle
      next_core.status = (core.status & ~clr) | ev;
      if (wr && I_WB_ADR == OFS_MASK) next_core.mask = I_WB_DAT[2:0];
      next_core.irq = |(next_core.status & next_core.mask);
      next_core.ack = I_WB_CYC && I_WB_STB && !core.ack;
      if (next_core.ack) begin
         case (I_WB_ADR)
            OFS_STATUS: next_core.dat = {29'h0, core.status};
            OFS_MASK: next_core.dat = {29'h0, core.mask};
            OFS_STATE: next_core.dat = {16'h0, idxf, idx2, idx1, 1'b0, test, I_REFERENCE_CHOOSER, core.lock};
            OFS_PERIOD: next_core.dat = {16'h0, core.per};
            default: next_core.dat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         core <= '{st: ST_ACQUIRE, status: STATUS_RESET, mask: MASK_RESET, default: '0};
      end else begin
         core <= next_core;
      end
   end

   assign O_WB_DAT = core.dat;
   assign O_WB_ACK = core.ack;
   assign O_BANK_ONE_CLOCK_OUTS = core.q1;
   assign O_BANK_ONE_OE = core.oe1;
   assign O_BANK_TWO_CLOCK_OUTS = core.q2;
   assign O_BANK_TWO_OE = core.oe2;
   assign O_FEEDBACK_CLOCK_OUT = core.qf;
   assign O_LOCK = core.lock;
   assign O_IRQ = core.irq;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   property p_ref_path;
      test |=> O_FEEDBACK_CLOCK_OUT == $past(I_REFERENCE_CHOOSER ? I_ALTERNATE_REFERENCE_PAIR : I_PRIMARY_REFERENCE_PAIR);
   endproperty
   a_ref_path: assert property (p_ref_path) else $error("reference choice wrong");

   property p_resync;
      ref_rise && !core.hit && !test && core.st != ST_TEST && core.pcnt != REF_TIMEOUT_CYC
         |=> core.good == 3'h0 && core.st == ST_ACQUIRE && !O_LOCK;
   endproperty
   a_resync: assert property (p_resync) else $error("missed edge did not resync");

   property p_lock_rise;
      $rose(O_LOCK) |-> core.good == LOCK_EDGES && $past(core.hit) && $past(ref_rise);
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock rose without aligned edges");

   property p_hiz;
      I_BANK_OFF_INPUTS[1] && off_high |=> !O_BANK_TWO_OE;
   endproperty
   a_hiz: assert property (p_hiz) else $error("bank two not high impedance");

   property p_enable;
      !I_BANK_OFF_INPUTS[0] && !test |=> O_BANK_ONE_OE;
   endproperty
   a_enable: assert property (p_enable) else $error("bank one not enabled");

   property p_park;
      core.h1 || $fell(core.h1) |-> O_BANK_ONE_CLOCK_OUTS == 4'h0;
   endproperty
   a_park: assert property (p_park) else $error("bank one pulse during hold-off");

   property p_test_unlock;
      test |=> !O_LOCK ##1 !O_LOCK;
   endproperty
   a_test_unlock: assert property (p_test_unlock) else $error("lock high in test mode");

   property p_div_top;
      I_FEEDBACK_DIVIDER_SELECTS == 4'ha && lvl(I_RANGE_SELECT) == LVL_HIGH |-> perf == 9'h060;
   endproperty
   a_div_top: assert property (p_div_top) else $error("divide by twelve wrong");

   property p_unit_low;
      I_BANK_DIVIDER_SELECTS[3:0] == 4'h0 && lvl(I_RANGE_SELECT) == LVL_LOW |-> per1 == 9'h020;
   endproperty
   a_unit_low: assert property (p_unit_low) else $error("low range factor wrong");

   property p_phase_low;
      I_BANK_ONE_PHASE_SELECTS[3:0] == 4'h0 |-> o1l == 5'sh1c && (pair_idx(I_BANK_TWO_PHASE_SELECTS[3:2],
         I_BANK_TWO_PHASE_SELECTS[1:0]) != 4'h3 || o2 == 5'sh1c);
   endproperty
   a_phase_low: assert property (p_phase_low) else $error("phase code offset wrong");

   property p_shared;
      I_BANK_ONE_PHASE_SELECTS[3:0] == I_BANK_ONE_PHASE_SELECTS[7:4] |=> O_BANK_ONE_CLOCK_OUTS[0] == O_BANK_ONE_CLOCK_OUTS[2];
   endproperty
   a_shared: assert property (p_shared) else $error("bank one outputs misaligned");

   property p_irq;
      O_IRQ == |(core.status & core.mask);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   property p_ack;
      O_WB_ACK |=> !O_WB_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");

   c_lock: cover property ($rose(O_LOCK));
   c_hold: cover property ($rose(core.h1));
   c_test: cover property ($rose(test) ##1 O_FEEDBACK_CLOCK_OUT);
   c_loss: cover property ($fell(O_LOCK) ##[1:20] O_IRQ);

endmodule : zero_delay_clock_bank_control

// *** verification/zdb_ref_model.sv ***
// reference clock source and board feedback trace facing the clock bank control
// assumes one system clock; references are whole numbers of its cycles
module zdb_ref_model #(
   parameter int PERIOD = 400,
   parameter int FB_DELAY = 1
) (
   input wire logic i_clk,
   input wire logic i_run_a,
   input wire logic i_run_b,
   input wire logic i_fb_out,
   output logic o_ref_a = 1'b0,
   output logic o_ref_b = 1'b0,
   output logic o_fb_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_a = 0;
   int cnt_b = 0;
   logic [2:0] fb_dly = 3'h0;
   wire logic [3:0] fb_taps = {fb_dly, i_fb_out};
   // ----------------------------------------
   // reference and feedback lines
   // ----------------------------------------
   // a stopped reference stands still low; only the true input of each pair is driven
   always @(posedge i_clk) begin
      cnt_a <= i_run_a ? (cnt_a + 1) % PERIOD : 0;
      cnt_b <= i_run_b ? (cnt_b + 1) % PERIOD : PERIOD / 3;
      o_ref_a <= i_run_a && (cnt_a >= PERIOD / 2);
      o_ref_b <= i_run_b && (cnt_b >= PERIOD / 2);
      fb_dly <= fb_taps[2:0];
   end
   assign o_fb_in = fb_taps[FB_DELAY];
endmodule : zdb_ref_model

// *** verification/zero_delay_clock_bank_control_tb_top.sv ***
// self-checking bench of the clock bank control: bus tasks and clock timing checks
// assumes the reference model on the far side, reference period 400 cycles, high range
module zero_delay_clock_bank_control_tb_top
   import zdb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = 400;
   localparam int TU = PER / 8;
   logic clk = 1'b0, rst_n = 1'b0, run_a = 1'b1, run_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic chooser = 1'b0;
   logic lock, irq, ack, fb_out, fb_in, ref_a, ref_b, oe1, oe2, r;
   logic [1:0] range_sel = LVL_HIGH;
   logic [1:0] mode = LVL_HIGH, off = 2'h0, fbph = LVL_MID;
   logic [3:0] adr = 4'h0, sel = 4'h0, ph2 = 4'h8, fbdiv = 4'h0, out1;
   logic [7:0] ph1 = 8'h85, div = 8'h00;
   logic [5:0] out2;
   logic [31:0] wdat = 32'h0, rdat, q;
   wire logic [4:0] sig = {ref_a, fb_out, out2[0], out1[2], out1[0]};
   int errors = 0, total_checks = 0, cyc_n = 0, t0, t1, t2, n;
   int dv[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};

   zero_delay_clock_bank_control zero_delay_clock_bank_control_i (
      .I_MCLK(clk), .I_RST_N(rst_n), .I_PRIMARY_REFERENCE_PAIR(ref_a), .I_ALTERNATE_REFERENCE_PAIR(ref_b),
      .I_REFERENCE_CHOOSER(chooser), .I_FEEDBACK_INPUT(fb_in), .I_RANGE_SELECT(range_sel), .I_MODE_SELECT(mode),
      .I_BANK_ONE_PHASE_SELECTS(ph1), .I_BANK_TWO_PHASE_SELECTS(ph2), .I_BANK_DIVIDER_SELECTS(div),
      .I_FEEDBACK_PHASE_SELECT(fbph), .I_FEEDBACK_DIVIDER_SELECTS(fbdiv), .I_BANK_OFF_INPUTS(off),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .O_WB_DAT(q), .O_WB_ACK(ack), .O_BANK_ONE_CLOCK_OUTS(out1), .O_BANK_ONE_OE(oe1),
      .O_BANK_TWO_CLOCK_OUTS(out2), .O_BANK_TWO_OE(oe2), .O_FEEDBACK_CLOCK_OUT(fb_out), .O_LOCK(lock), .O_IRQ(irq)
   );
   zdb_ref_model #(.PERIOD(PER), .FB_DELAY(1)) zdb_ref_model_i (
      .i_clk(clk), .i_run_a(run_a), .i_run_b(run_b), .i_fb_out(fb_out),
      .o_ref_a(ref_a), .o_ref_b(ref_b), .o_fb_in(fb_in)
   );

   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc_n <= cyc_n + 1;

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask : chk

   task automatic give_up(input string nm);
      $display("FAIL %s expected event seen timeout", nm);
      errors++;
      close_out();
   endtask : give_up

   // entered just after a rising edge; holds the request until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      @(posedge clk);
      while (ack !== 1'b1) begin
         @(posedge clk);
         k++;
         if (k > 20) give_up("bus ack");
      end
      rdat = q;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      @(posedge clk);
   endtask : wb

   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rdat & m);
   endtask : rd

   task automatic rise(input int w, output int t);
      logic p;
      int k;
      p = sig[w];
      k = 0;
      forever begin
         @(posedge clk);
         if (sig[w] === 1'b1 && p === 1'b0) break;
         p = sig[w];
         k++;
         if (k > 6000) give_up("clock edge");
      end
      t = cyc_n;
   endtask : rise

   // lock loss needs the 2000-cycle reference timeout, so the bound is generous
   task automatic wait_lock(input logic v);
      int k;
      k = 0;
      while (lock !== v) begin
         @(posedge clk);
         k++;
         if (k > 8000) give_up("lock");
      end
   endtask : wait_lock

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      chk("reset outputs", 32'h0, 32'({oe1, oe2, lock, irq, ack, out1, out2, fb_out}));
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFS_STATUS, 32'h7, 32'(STATUS_RESET), "status reset");
      rd(OFS_MASK, 32'h7, 32'(MASK_RESET), "mask reset");
      wb(1'b1, OFS_MASK, 32'h7);
      rd(OFS_MASK, 32'h7, 32'h7, "mask rw");
      wb(1'b1, OFS_MASK, 32'h0);
      wb(1'b1, OFS_STATE, 32'hffff);
      rd(OFS_STATE, 32'hfff7, 32'h0, "state read only");
      wait_lock(1'b1);
      rise(4, t0);
      rise(3, t1);
      chk("feedback aligned", 32'h1, 32'(((t1 - t0 + 2) % PER) < 5));
      rd(OFS_STATUS, 32'h7, 32'h1, "lock gain event");
      chk("irq masked", 32'h0, 32'(irq));
      wb(1'b1, OFS_MASK, 32'h1);
      @(posedge clk);
      chk("irq raised", 32'h1, 32'(irq));
      wb(1'b1, OFS_STATUS, 32'h1);
      @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
      rd(OFS_STATUS, 32'h7, 32'h0, "status cleared");
      wb(1'b1, OFS_MASK, 32'h0);
      rise(0, t0);
      rise(1, t1);
      rise(2, t2);
      chk("phase bank one upper", 2 * TU, t1 - t0);
      chk("phase bank two", 6 * TU, t2 - t0);
      for (int i = 0; i < 9; i++) begin
         div <= {2'((8 - i) / 3), 2'((8 - i) % 3), 2'(i / 3), 2'(i % 3)};
         @(posedge clk);
         rd(OFS_STATE, 32'hfff0, {16'h0, 4'h0, 4'(8 - i), 4'(i), 4'h0}, "divider index");
         rise(0, t0);
         rise(0, t0);
         rise(0, t1);
         chk("bank one period", dv[i] * PER, t1 - t0);
         chk("bank one pairs", 32'({out1[0], out1[2]}), 32'({out1[1], out1[3]}));
      end
      off <= 2'h1;
      // bank one back to divide by one so its hold-off entry comes within the wait below
      div <= 8'h00;
      repeat (4) @(posedge clk);
      chk("high-z disable", 32'h2, 32'({oe2, oe1}));
      mode <= LVL_LOW;
      off <= 2'h3;
      repeat (450) @(posedge clk);
      chk("hold-off enables", 32'h3, 32'({oe2, oe1}));
      n = 0;
      repeat (800) begin
         @(posedge clk);
         n += int'(out2[0] !== 1'b0 || out1 !== 4'h0);
      end
      chk("hold-off parked", 32'h0, n);
      off <= 2'h0;
      rise(2, t0);
      n = 0;
      while (out2[0] === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk("first pulse width", PER / 2, n);
      run_b <= 1'b1;
      run_a <= 1'b0;
      wait_lock(1'b0);
      rd(OFS_STATUS, 32'h7, 32'h2, "lock loss event");
      chooser <= 1'b1;
      wait_lock(1'b1);
      rd(OFS_STATUS, 32'h7, 32'h7, "swap and regain");
      rd(OFS_STATE, 32'h7, 32'h3, "state lock chooser");
      mode <= LVL_MID;
      repeat (4) @(posedge clk);
      rd(OFS_STATE, 32'h7, 32'h6, "test mode state");
      n = 0;
      repeat (PER) begin
         r = ref_b;
         @(posedge clk);
         n += int'(out1[0] !== r);
      end
      chk("test mode copies reference", 32'h0, n);
      fbdiv <= 4'ha;
      @(posedge clk);
      rd(OFS_STATE, 32'hf000, 32'h8000, "feedback divider index");
      // low range, lowest bank one phase codes and the bank two code that follows bank one lower reach the decode assertions of the core
      ph1 <= 8'h00;
      ph2 <= 4'h4;
      range_sel <= LVL_LOW;
      repeat (4) @(posedge clk);
      rd(OFS_STATE, 32'hffff, 32'h8006, "state after range change");
      close_out();
   end
endmodule : zero_delay_clock_bank_control_tb_top
